// ### bench/mimcr_host.sv
// Serial-bus host model issuing single-byte register accesses
`default_nettype none
module mimcr_host
  import mimcr_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register port
  output var mimcr_req_type req,
  input  wire logic [7:0]  rdata,
  input  wire logic        rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  // Each access opens one edge after the last, so req never changes twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit late);
    int n;
    @(posedge clk);
    #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    #1;
    req = '0;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    late = (rvalid !== 1'b1);
    d = rdata;
  endtask : rd
endmodule : mimcr_host
`default_nettype wire

// ### bench/mimcr_props.sv
// Assertion checker for the mask and configuration bank
`default_nettype none
module mimcr_props
  import mimcr_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
)(
  // Clock and reset
  input wire logic          CLK,
  input wire logic          CE,
  input wire logic          RESET_N,
  // Inputs
  input wire mimcr_req_type REQ,
  input wire mimcr_cfg_type CFG,
  input wire logic [7:0]    STATUS_FIRST,
  input wire logic [7:0]    STATUS_SECOND,
  // Outputs
  input wire logic          INT_OUT_N,
  input wire logic          RESET_OUT_N,
  input wire logic          CHASSIS_INTRUSION_OUT,
  input wire logic          CHASSIS_INTRUSION_OE_N,
  input wire logic          CFG_INTR_BIT,
  input wire logic          CFG_RESET_BIT,
  input wire logic [1:0]    TACH_1_DIV,
  input wire logic [1:0]    TACH_2_DIV
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] oe_low_q;
  logic [31:0] rst_low_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Width is judged as the pin returns high: only the minimum is promised
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N) oe_low_q <= 32'h0;
    else oe_low_q <= CHASSIS_INTRUSION_OE_N ? 32'h0 : oe_low_q + 32'h1;
  end
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N) rst_low_q <= 32'h0;
    else rst_low_q <= RESET_OUT_N ? 32'h0 : rst_low_q + 32'h1;
  end
  chk_int_off_high: assert property (CE && !CFG.int_enable |=> INT_OUT_N)
    else $error("int asserted while disabled");
  chk_int_no_source: assert property
    (CE && (STATUS_FIRST & 8'hdf) == 8'h00 && (STATUS_SECOND & 8'h13) == 8'h00 |=> INT_OUT_N)
    else $error("int asserted without source");
  chk_intr_drive_low: assert property (!CHASSIS_INTRUSION_OUT)
    else $error("intrusion pin driven high");
  chk_intr_bit_set: assert property ($fell(CHASSIS_INTRUSION_OE_N) |-> CFG_INTR_BIT)
    else $error("intrusion bit low in pulse");
  chk_intr_width: assert property ($rose(CHASSIS_INTRUSION_OE_N) |-> oe_low_q >= PULSE_LEN)
    else $error("intrusion pulse too short");
  chk_reset_width: assert property ($rose(RESET_OUT_N) |-> rst_low_q >= PULSE_LEN)
    else $error("reset pulse too short");
  chk_reset_bit_set: assert property ($fell(RESET_OUT_N) |-> CFG_RESET_BIT)
    else $error("reset bit low in pulse");
  chk_tach_by_write: assert property
    ($changed({TACH_2_DIV, TACH_1_DIV}) |-> $past(CE && (CFG.init || REQ.wr && REQ.addr == ADDR_VID_DIV), 2))
    else $error("divisor changed without write");
endmodule : mimcr_props
bind mimcr_regs mimcr_props #(.PULSE_LEN(PULSE_LEN)) u_props (
  .CLK(CLK), .CE(CE), .RESET_N(RESET_N), .REQ(REQ), .CFG(CFG), .STATUS_FIRST(STATUS_FIRST),
  .STATUS_SECOND(STATUS_SECOND), .INT_OUT_N(INT_OUT_N), .RESET_OUT_N(RESET_OUT_N),
  .CHASSIS_INTRUSION_OUT(CHASSIS_INTRUSION_OUT), .CHASSIS_INTRUSION_OE_N(CHASSIS_INTRUSION_OE_N),
  .CFG_INTR_BIT(CFG_INTR_BIT), .CFG_RESET_BIT(CFG_RESET_BIT), .TACH_1_DIV(TACH_1_DIV),
  .TACH_2_DIV(TACH_2_DIV));
`default_nettype wire

// ### bench/testbench.sv
// Bench for the mask and configuration bank: reset values, fields, masking, pin pulses
`default_nettype none
module testbench
  import mimcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PL = 20;
  localparam logic [15:0] SRC = 16'h13df;
  logic          clk = 1'b0;
  logic          ce = 1'b1;
  logic          rst_n = 1'b0;
  mimcr_req_type req;
  mimcr_cfg_type cfg = '0;
  logic [7:0]    st1 = 8'h00;
  logic [7:0]    st2 = 8'h00;
  logic          half = 1'b1;
  logic [3:0]    cpu_voltage_id = 4'ha;
  logic          cpu_voltage_id_bit4 = 1'b1;
  logic          s_hi = 1'b1;
  logic          s_lo = 1'b0;
  logic [7:0]    rdata;
  logic          rvalid, int_n, rst_o_n, oe_n, cfg_rst, cfg_intr;
  logic [1:0]    t1, t2, mode;
  logic [6:0]    saddr;
  logic [7:0]    ra [9] = '{8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4b, 8'h4a};
  logic [7:0]    rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h2e, 8'h81, 8'h81, 8'h00};
  int            errors = 0;
  int            cmp_count = 0;
  int            i;
  int            n;
  always #12.5 clk = ~clk;
  mimcr_regs #(.PULSE_LEN(PL)) dut (
    .CLK(clk), .CE(ce), .RESET_N(rst_n), .REQ(req), .RDATA(rdata), .RVALID(rvalid), .CFG(cfg),
    .CFG_RESET_BIT(cfg_rst), .CFG_INTR_BIT(cfg_intr), .STATUS_FIRST(st1), .STATUS_SECOND(st2),
    .TEMP_HALF_LSB(half), .CPU_VOLTAGE_ID(cpu_voltage_id), .CPU_VOLTAGE_ID_BIT4(cpu_voltage_id_bit4), .ADDR_STRAP_HI(s_hi),
    .ADDR_STRAP_LO(s_lo), .INT_OUT_N(int_n), .RESET_OUT_N(rst_o_n), .CHASSIS_INTRUSION_OUT(),
    .CHASSIS_INTRUSION_OE_N(oe_n), .TACH_1_DIV(t1), .TACH_2_DIV(t2), .TEMP_IRQ_MODE(mode),
    .SLAVE_ADDR(saddr));
  mimcr_host h (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("%0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit late;
    h.rd(a, d, late);
    if (late)
    begin
      errors++;
      close_out();
    end
    else
      check(d, exp);
  endtask : rd_chk
  // Config-register side requests are single-cycle pulses
  task automatic pulse(input bit reset_kind);
    cfg.reset_req = reset_kind;
    cfg.intr_wr = !reset_kind;
    cfg.intr_wdata = 1'b1;
    cyc(1);
    cfg.reset_req = 1'b0;
    cfg.intr_wr = 1'b0;
  endtask : pulse
  task automatic low_time(input bit pick_reset, output int cnt);
    cnt = 0;
    while ((pick_reset ? rst_o_n : oe_n) === 1'b0 && cnt < 4 * PL)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt == 4 * PL)
    begin
      errors++;
      close_out();
    end
  endtask : low_time
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cyc(6);
    for (i = 0; i < 9; i++) rd_chk(ra[i], rv[i]);
    $display("reset values done");
    h.wr(ADDR_SPARE, 8'ha5);
    rd_chk(ADDR_SPARE, 8'ha5);
    h.wr(ADDR_INTR_CLEAR, 8'h7f);
    rd_chk(ADDR_INTR_CLEAR, 8'h7f);
    h.wr(ADDR_VID_BIT4, 8'h00);
    rd_chk(ADDR_VID_BIT4, 8'h01);
    h.wr(ADDR_SLAVE, 8'h81);
    rd_chk(ADDR_SLAVE, 8'h82);
    {s_hi, s_lo} = 2'b01;
    cyc(6);
    rd_chk(ADDR_SLAVE, 8'h81);
    check({1'b0, saddr}, 8'h01);
    for (i = 0; i < 4; i++)
    begin
      h.wr(ADDR_VID_DIV, {i[1:0], ~i[1:0], 4'hf});
      rd_chk(ADDR_VID_DIV, {i[1:0], ~i[1:0], cpu_voltage_id});
      check({4'h0, t2, t1}, {4'h0, i[1:0], ~i[1:0]});
      h.wr(ADDR_TEMP_CFG, {6'h3f, i[1:0]});
      cyc(1);
      check({6'h00, mode}, {6'h00, i[1:0]});
    end
    rd_chk(ADDR_TEMP_CFG, 8'hff);
    half = 1'b0;
    rd_chk(ADDR_TEMP_CFG, 8'h7f);
    $display("field access done");
    cfg.int_enable = 1'b1;
    for (i = 0; i < 16; i++)
    begin
      {st2, st1} = 16'h0001 << i;
      cyc(2);
      check({7'h00, int_n}, {7'h00, ~SRC[i]});
      h.wr(i < 8 ? ADDR_MASK_FIRST : ADDR_MASK_SECOND, 8'h01 << i[2:0]);
      cyc(1);
      check({7'h00, int_n}, 8'h01);
      h.wr(i < 8 ? ADDR_MASK_FIRST : ADDR_MASK_SECOND, 8'h00);
    end
    {st2, st1} = 16'h0001;
    cfg.int_enable = 1'b0;
    cyc(2);
    check({7'h00, int_n}, 8'h01);
    $display("masking done");
    for (i = 0; i < 2; i++)
    begin
      if (i == 0)
        h.wr(ADDR_INTR_CLEAR, 8'hff);
      else
        pulse(1'b0);
      rd_chk(ADDR_INTR_CLEAR, 8'hff);
      check({6'h00, cfg_intr, oe_n}, 8'h02);
      // Counting starts one cycle into the pulse
      low_time(1'b0, n);
      check({7'h00, n + 1 >= PL}, 8'h01);
      rd_chk(ADDR_INTR_CLEAR, 8'h7f);
    end
    $display("intrusion pulse done");
    // Without the enable in the second mask the request is dropped, not held
    pulse(1'b1);
    cyc(3);
    check({6'h00, cfg_rst, rst_o_n}, 8'h01);
    h.wr(ADDR_MASK_SECOND, 8'h80);
    pulse(1'b1);
    cyc(2);
    check({6'h00, cfg_rst, rst_o_n}, 8'h02);
    low_time(1'b1, n);
    check({7'h00, n + 1 >= PL}, 8'h01);
    cyc(1);
    check({6'h00, cfg_rst, rst_o_n}, 8'h01);
    $display("reset pulse done");
    // Initialisation restores the masks but leaves the spare register alone
    h.wr(ADDR_MASK_FIRST, 8'hff);
    cfg.init = 1'b1;
    cyc(1);
    cfg.init = 1'b0;
    rd_chk(ADDR_MASK_FIRST, RST_MASK_FIRST);
    rd_chk(ADDR_SPARE, 8'ha5);
    $display("initialisation done");
    close_out();
  end
endmodule : testbench
`default_nettype wire

// ### rtl/mimcr_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`default_nettype none
module mimcr_pin_sync
  import mimcr_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  // Pin and clean level
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      level <= '0;
    end
    else if (ce)
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Single-sample glitches never reach the register file
      for (int i = 0; i < WIDTH; i++)
      begin
        if (s2_q[i] == s3_q[i])
          level[i] <= s3_q[i];
      end
    end
  end
endmodule : mimcr_pin_sync
`default_nettype wire

// ### rtl/mimcr_pkg.sv
// Package for the monitor interrupt-mask and configuration register bank
// Contract
// - Mask register 43h bits 0-4,6,7 block their status sources from the interrupt output.
// - Mask register 44h bits 0,1,4 block 12V, core supply 2 and intrusion sources.
// - Bit 7 of 44h enables the configuration reset-pulse request.
// - Register 45h is plain read/write storage, zero after power-on, no effect.
// - Writing one to 46h bit 7 pulls intrusion pin low 20 ms, then self-clears.
// - Intrusion-clear bit is shared with configuration bit 6; both locations read alike.
// - Register 47h bits 3:0 read the low identification pins; upper nibble resets 0101.
// - Bits 5:4 of 47h select tach 1 divide by 1, 2, 4 or 8.
// - Bits 7:6 of 47h select tach 2 divide by 1, 2, 4 or 8.
// - Register 48h bits 6:2 writable address, reset 01011; bit 7 storage, reset zero.
// - Register 48h bits 1:0 read the two address strap pins.
// - Register 49h bit 0 reads identification pin 4; bits 7:1 are storage.
// - Register 4Bh bits 1:0 select repetitive, one-time or comparator temperature interrupts.
// - Register 4Bh bit 7 reads temperature half-degree bit; bits 6:2 are storage.
// - Interrupt output asserts only while configuration interrupt-enable is one.
// - Configuration reset bit drives reset low at least 20 ms, then self-clears.
`default_nettype none
package mimcr_pkg;
  localparam logic [7:0] ADDR_MASK_FIRST   = 8'h43;
  localparam logic [7:0] ADDR_MASK_SECOND  = 8'h44;
  localparam logic [7:0] ADDR_SPARE        = 8'h45;
  localparam logic [7:0] ADDR_INTR_CLEAR   = 8'h46;
  localparam logic [7:0] ADDR_VID_DIV      = 8'h47;
  localparam logic [7:0] ADDR_SLAVE        = 8'h48;
  localparam logic [7:0] ADDR_VID_BIT4     = 8'h49;
  localparam logic [7:0] ADDR_TEMP_CFG     = 8'h4b;

  localparam logic [7:0] RST_MASK_FIRST    = 8'h00;
  localparam logic [7:0] RST_MASK_SECOND   = 8'h00;
  localparam logic [7:0] RST_SPARE         = 8'h00;
  localparam logic [6:0] RST_INTR_SPARE    = 7'h00;
  localparam logic [3:0] RST_VID_DIV_HI    = 4'h5;
  localparam logic [4:0] RST_SLAVE_HI      = 5'h0b;
  localparam logic       RST_SLAVE_B7      = 1'b0;
  localparam logic [6:0] RST_CPU_VOLTAGE_ID_BIT4_SPARE    = 7'h40;
  localparam logic [7:0] RST_TEMP_CFG      = 8'h01;

  // Sources that can reach the interrupt output
  localparam logic [7:0] SRC_FIRST         = 8'hdf;
  localparam logic [7:0] SRC_SECOND        = 8'h13;
  localparam int         BIT_RESET_EN      = 7;
  localparam int         BIT_INTR_CLEAR    = 7;

  localparam int unsigned PULSE_TIME_MS    = 20;
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned PULSE_CYCLES     = (PULSE_TIME_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned SYNC_STAGES      = 3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mimcr_req_type;

  typedef struct packed {
    logic       int_enable;
    logic       reset_req;
    logic       intr_wr;
    logic       intr_wdata;
    logic       init;
  } mimcr_cfg_type;

  typedef enum logic [1:0] {
    MODE_REPEAT  = 2'b00,
    MODE_ONCE    = 2'b01,
    MODE_COMPARE = 2'b10,
    MODE_REPEAT2 = 2'b11
  } mimcr_temp_mode_type;
endpackage : mimcr_pkg
`default_nettype wire

// ### rtl/mimcr_pulse.sv
// Fixed-length low pulse timer for the reset and intrusion pins
`default_nettype none
module mimcr_pulse
  import mimcr_pkg::*;
#(
  parameter int unsigned CYCLES = PULSE_CYCLES
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  // Control
  input  wire logic start,
  output logic      busy
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= '0;
      busy  <= 1'b0;
    end
    else if (ce)
    begin
      if (!busy && start)
      begin
        cnt_q <= CW'(CYCLES - 1);
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        if (cnt_q == '0)
          busy <= 1'b0;
        else
          cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : mimcr_pulse
`default_nettype wire

// ### rtl/mimcr_regs.sv
// Interrupt mask, intrusion clear, divisor, address and temperature configuration registers
`default_nettype none
module mimcr_regs
  import mimcr_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
)(
  // Clock, enable and reset
  input  wire logic          CLK,
  input  wire logic          CE,
  input  wire logic          RESET_N,
  // Register port from the serial interface
  input  wire mimcr_req_type REQ,
  output logic [7:0]         RDATA,
  output logic               RVALID,
  // Configuration register links
  input  wire mimcr_cfg_type CFG,
  output logic               CFG_RESET_BIT,
  output logic               CFG_INTR_BIT,
  // Interrupt status from the limit checker
  input  wire logic [7:0]    STATUS_FIRST,
  input  wire logic [7:0]    STATUS_SECOND,
  input  wire logic          TEMP_HALF_LSB,
  // Pins sampled from outside
  input  wire logic [3:0]    CPU_VOLTAGE_ID,
  input  wire logic          CPU_VOLTAGE_ID_BIT4,
  input  wire logic          ADDR_STRAP_HI,
  input  wire logic          ADDR_STRAP_LO,
  // Pin drivers
  output logic               INT_OUT_N,
  output logic               RESET_OUT_N,
  output logic               CHASSIS_INTRUSION_OUT,
  output logic               CHASSIS_INTRUSION_OE_N,
  // Settings for the monitor core
  output logic [1:0]         TACH_1_DIV,
  output logic [1:0]         TACH_2_DIV,
  output logic [1:0]         TEMP_IRQ_MODE,
  output logic [6:0]         SLAVE_ADDR
);
  logic [7:0] mask_first_q;
  logic [7:0] mask_second_q;
  logic [7:0] spare_q;
  logic [6:0] intr_spare_q;
  logic [3:0] vid_div_hi_q;
  logic [4:0] slave_hi_q;
  logic       slave_b7_q;
  logic [6:0] cpu_voltage_id_bit4_spare_q;
  logic [7:0] temp_cfg_q;

  logic [3:0] vid_s;
  logic       cpu_voltage_id_bit4_s;
  logic [1:0] strap_s;
  logic       reset_busy;
  logic       intr_busy;
  logic       reset_start;
  logic       intr_start;
  logic       irq_pending;

  // Decode of a write strobe to one location
  function automatic logic hit(input mimcr_req_type r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // Read mux shared by the data path and nowhere else, kept a function for clarity
  function automatic logic [7:0] read_value(input logic [7:0] a);
    unique case (a)
      ADDR_MASK_FIRST:  read_value = mask_first_q;
      ADDR_MASK_SECOND: read_value = mask_second_q;
      ADDR_SPARE:       read_value = spare_q;
      ADDR_INTR_CLEAR:  read_value = {intr_busy, intr_spare_q};
      ADDR_VID_DIV:     read_value = {vid_div_hi_q, vid_s};
      ADDR_SLAVE:       read_value = {slave_b7_q, slave_hi_q, strap_s};
      ADDR_VID_BIT4:    read_value = {cpu_voltage_id_bit4_spare_q, cpu_voltage_id_bit4_s};
      ADDR_TEMP_CFG:    read_value = {TEMP_HALF_LSB, temp_cfg_q[6:0]};
      default:          read_value = 8'h00;
    endcase
  endfunction : read_value

  mimcr_pin_sync #(
    .WIDTH (7)
  ) u_pin_sync (
    .clk     (CLK),
    .reset_n (RESET_N),
    .ce      (CE),
    .pin     ({CPU_VOLTAGE_ID_BIT4, CPU_VOLTAGE_ID, ADDR_STRAP_HI, ADDR_STRAP_LO}),
    .level   ({cpu_voltage_id_bit4_s, vid_s, strap_s})
  );

  // Reset request is dropped unless enabled; the bit then never reads one
  assign reset_start = CFG.reset_req && mask_second_q[BIT_RESET_EN];

  // Either location starts the intrusion pulse
  assign intr_start = (hit(REQ, ADDR_INTR_CLEAR) && REQ.wdata[BIT_INTR_CLEAR])
                    || (CFG.intr_wr && CFG.intr_wdata);

  mimcr_pulse #(
    .CYCLES (PULSE_LEN)
  ) u_reset_pulse (
    .clk     (CLK),
    .reset_n (RESET_N),
    .ce      (CE),
    .start   (reset_start),
    .busy    (reset_busy)
  );

  mimcr_pulse #(
    .CYCLES (PULSE_LEN)
  ) u_intr_pulse (
    .clk     (CLK),
    .reset_n (RESET_N),
    .ce      (CE),
    .start   (intr_start),
    .busy    (intr_busy)
  );

  // Mask registers
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      mask_first_q  <= RST_MASK_FIRST;
      mask_second_q <= RST_MASK_SECOND;
    end
    else if (CE)
    begin
      if (CFG.init)
      begin
        mask_first_q  <= RST_MASK_FIRST;
        mask_second_q <= RST_MASK_SECOND;
      end
      else
      begin
        if (hit(REQ, ADDR_MASK_FIRST))
          mask_first_q <= REQ.wdata;
        if (hit(REQ, ADDR_MASK_SECOND))
          mask_second_q <= REQ.wdata;
      end
    end
  end

  // Spare storage; initialisation leaves it alone like the address register
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      spare_q <= RST_SPARE;
    else if (CE && hit(REQ, ADDR_SPARE))
      spare_q <= REQ.wdata;
  end

  // Intrusion clear register low bits
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      intr_spare_q <= RST_INTR_SPARE;
    else if (CE)
    begin
      if (CFG.init)
        intr_spare_q <= RST_INTR_SPARE;
      else if (hit(REQ, ADDR_INTR_CLEAR))
        intr_spare_q <= REQ.wdata[6:0];
    end
  end

  // Fan divisors
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      vid_div_hi_q <= RST_VID_DIV_HI;
    else if (CE)
    begin
      if (CFG.init)
        vid_div_hi_q <= RST_VID_DIV_HI;
      else if (hit(REQ, ADDR_VID_DIV))
        vid_div_hi_q <= REQ.wdata[7:4];
    end
  end

  // Serial address; not in the initialisation set
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      slave_hi_q <= RST_SLAVE_HI;
      slave_b7_q <= RST_SLAVE_B7;
    end
    else if (CE && hit(REQ, ADDR_SLAVE))
    begin
      slave_hi_q <= REQ.wdata[6:2];
      slave_b7_q <= REQ.wdata[7];
    end
  end

  // Identification bit 4 register spare bits
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      cpu_voltage_id_bit4_spare_q <= RST_CPU_VOLTAGE_ID_BIT4_SPARE;
    else if (CE)
    begin
      if (CFG.init)
        cpu_voltage_id_bit4_spare_q <= RST_CPU_VOLTAGE_ID_BIT4_SPARE;
      else if (hit(REQ, ADDR_VID_BIT4))
        cpu_voltage_id_bit4_spare_q <= REQ.wdata[7:1];
    end
  end

  // Temperature configuration; bit 7 is never stored
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      temp_cfg_q <= RST_TEMP_CFG;
    else if (CE)
    begin
      if (CFG.init)
        temp_cfg_q <= RST_TEMP_CFG;
      else if (hit(REQ, ADDR_TEMP_CFG))
        temp_cfg_q <= {1'b0, REQ.wdata[6:0]};
    end
  end

  // Read data port
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      RDATA  <= 8'h00;
      RVALID <= 1'b0;
    end
    else if (CE)
    begin
      RVALID <= REQ.rd;
      if (REQ.rd)
        RDATA <= read_value(REQ.addr);
    end
  end

  // Status is only read here, never altered, so masked events still latch upstream
  assign irq_pending = |(STATUS_FIRST & SRC_FIRST & ~mask_first_q)
                     || |(STATUS_SECOND & SRC_SECOND & ~mask_second_q);

  // Pin drivers and settings, all registered
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      INT_OUT_N              <= 1'b1;
      RESET_OUT_N            <= 1'b1;
      CHASSIS_INTRUSION_OUT  <= 1'b0;
      CHASSIS_INTRUSION_OE_N <= 1'b1;
      CFG_RESET_BIT          <= 1'b0;
      CFG_INTR_BIT           <= 1'b0;
    end
    else if (CE)
    begin
      INT_OUT_N              <= !(CFG.int_enable && irq_pending);
      RESET_OUT_N            <= !reset_busy;
      CHASSIS_INTRUSION_OUT  <= 1'b0;
      CHASSIS_INTRUSION_OE_N <= !intr_busy;
      CFG_RESET_BIT          <= reset_busy;
      CFG_INTR_BIT           <= intr_busy;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      TACH_1_DIV    <= RST_VID_DIV_HI[1:0];
      TACH_2_DIV    <= RST_VID_DIV_HI[3:2];
      TEMP_IRQ_MODE <= RST_TEMP_CFG[1:0];
      SLAVE_ADDR    <= {RST_SLAVE_HI, 2'b00};
    end
    else if (CE)
    begin
      TACH_1_DIV    <= vid_div_hi_q[1:0];
      TACH_2_DIV    <= vid_div_hi_q[3:2];
      TEMP_IRQ_MODE <= temp_cfg_q[1:0];
      SLAVE_ADDR    <= {slave_hi_q, strap_s};
    end
  end
endmodule : mimcr_regs
`default_nettype wire
